// *** design/uht_top.sv ***
/*
 upper half of a 32-bit timer pair: control register, 16-bit counter,
 gated accumulation, external count pin, wishbone classic slave.
 assumes pair_32bit_mode and the lower control bits come from the lower
 timer on the same clock; pins arrive asynchronously.
*/
// The Wishbone interface to the registers and the register addresses were decided locally.
// Behaviour
// - run bit set starts the 16-bit count; clear stops it
// - idle_halt set stops the timer while the device is idle
// - idle_halt clear keeps the timer running in idle
// - internal source with gate enable gives gated time accumulation
// - external source ignores the gate enable bit
// - source set counts external pin rising edges, clear counts clk
// - in 32-bit pair mode the lower control register governs all but idle_halt
// - external count pin may be omitted per instance
`timescale 1ns/1ps
module uht_top
    import uht_pkg::*;
#(
    parameter bit HAS_EXT_PIN = 1'b1
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // device and pair state
    input wire logic device_idle,
    input wire logic pair_32bit_mode,
    input wire logic [15:0] lower_timer_control,
    // pins
    input wire logic external_count_pin,
    input wire logic gate_pin,
    // status out
    output logic [15:0] count_out,
    output logic counting
);
    import uht_pkg::*;

    // ------------------------------------------------------------------
    // pin synchronisers and edge detect
    // ------------------------------------------------------------------
    logic [1:0] ext_sync_r;
    logic [1:0] ext_sync_nxt;
    logic ext_prev_r;
    logic ext_prev_nxt;
    logic [1:0] gate_sync_r;
    logic [1:0] gate_sync_nxt;
    logic ext_rise;

    always_comb
    begin
        // absent pin is held low so no edges ever appear
        ext_sync_nxt = {ext_sync_r[0], HAS_EXT_PIN & external_count_pin};
        ext_prev_nxt = ext_sync_r[1];
        gate_sync_nxt = {gate_sync_r[0], gate_pin};
        ext_rise = ext_sync_r[1] & ~ext_prev_r;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ext_sync_r <= 2'h0;
            ext_prev_r <= 1'b0;
            gate_sync_r <= 2'h0;
        end
        else
        begin
            ext_sync_r <= ext_sync_nxt;
            ext_prev_r <= ext_prev_nxt;
            gate_sync_r <= gate_sync_nxt;
        end
    end

    // ------------------------------------------------------------------
    // effective settings
    // ------------------------------------------------------------------
    logic [15:0] ctrl_r;
    logic [15:0] ctrl_nxt;
    logic [15:0] eff;
    logic run_eff;
    logic gate_eff;
    logic src_ext;
    logic halted;
    logic gate_hi;

    always_comb
    begin
        // pair mode: lower control register takes over
        eff = pair_32bit_mode ? lower_timer_control : ctrl_r;
        src_ext = eff[UHT_SRC_POS];
        gate_eff = eff[UHT_GATE_POS] & ~src_ext;
        // idle halt stays this register's own bit even in pair mode
        halted = device_idle & ctrl_r[UHT_IDLE_POS];
        run_eff = eff[UHT_RUN_POS] & ~halted;
        gate_hi = gate_sync_r[1];
    end

    // ------------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------------
    uht_tick_if tif ();

    always_comb
    begin
        tif.enable = run_eff & (~gate_eff | gate_hi);
        tif.ps_sel = eff[UHT_PS_LSB +: 2];
        tif.raw_tick = src_ext ? ext_rise : 1'b1;
    end

    uht_prescaler u_pre (
        .clk(clk),
        .rst(rst),
        .tif(tif)
    );

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic ack_r;
    logic ack_nxt;
    logic [31:0] dat_r;
    logic [31:0] dat_nxt;
    logic req;

    always_comb
    begin
        req = cyc_i & stb_i & ~ack_r;
        cnt_nxt = cnt_r;
        if (tif.tick)
            cnt_nxt = cnt_r + 16'h0001;
        if (req && we_i && adr_i == UHT_COUNT_OFS)
        begin
            if (sel_i[0])
                cnt_nxt[7:0] = dat_i[7:0];
            if (sel_i[1])
                cnt_nxt[15:8] = dat_i[15:8];
        end
    end

    // ------------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------------
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        ack_nxt = req;
        dat_nxt = dat_r;
        if (req && we_i && adr_i == UHT_CTRL_OFS)
        begin
            if (sel_i[0])
                ctrl_nxt[7:0] = dat_i[7:0] & UHT_CTRL_MASK[7:0];
            if (sel_i[1])
                ctrl_nxt[15:8] = dat_i[15:8] & UHT_CTRL_MASK[15:8];
        end
        if (req && !we_i)
        begin
            unique case (adr_i)
                UHT_CTRL_OFS: dat_nxt = {16'h0000, ctrl_r};
                UHT_COUNT_OFS: dat_nxt = {16'h0000, cnt_r};
                UHT_STAT_OFS: dat_nxt = {29'h0, halted, pair_32bit_mode,
                    tif.enable};
                // unmapped reads answer zero
                default: dat_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl_r <= UHT_CTRL_RST;
            cnt_r <= UHT_COUNT_RST;
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            cnt_r <= cnt_nxt;
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    assign ack_o = ack_r;
    assign dat_o = dat_r;
    assign count_out = cnt_r;
    assign counting = tif.enable;
endmodule

// *** design/uht_pkg.sv ***
/*
 upper-half timer package: register map, field positions, reset values,
 prescale codes. assumes a 32-bit wishbone word per register.
*/
package uht_pkg;
    // --------------------------------------------------------------
    // register map
    // --------------------------------------------------------------
    localparam logic [3:0] UHT_CTRL_OFS = 4'h0;
    localparam logic [3:0] UHT_COUNT_OFS = 4'h4;
    localparam logic [3:0] UHT_STAT_OFS = 4'h8;
    localparam logic [15:0] UHT_CTRL_RST = 16'h0000;
    localparam logic [15:0] UHT_CTRL_MASK = 16'hA072;
    localparam logic [15:0] UHT_COUNT_RST = 16'h0000;
    // --------------------------------------------------------------
    // control fields
    // --------------------------------------------------------------
    localparam int UHT_RUN_POS = 15;
    localparam int UHT_IDLE_POS = 13;
    localparam int UHT_GATE_POS = 6;
    localparam int UHT_PS_LSB = 4;
    localparam int UHT_SRC_POS = 1;
    // --------------------------------------------------------------
    // prescale codes and terminal counts
    // --------------------------------------------------------------
    localparam logic [1:0] UHT_PS_1 = 2'h0;
    localparam logic [1:0] UHT_PS_8 = 2'h1;
    localparam logic [1:0] UHT_PS_64 = 2'h2;
    localparam logic [1:0] UHT_PS_256 = 2'h3;
    localparam logic [7:0] UHT_TC_1 = 8'h00;
    localparam logic [7:0] UHT_TC_8 = 8'h07;
    localparam logic [7:0] UHT_TC_64 = 8'h3F;
    localparam logic [7:0] UHT_TC_256 = 8'hFF;
    localparam logic [7:0] UHT_PS_RST = 8'h00;
endpackage

// *** design/uht_tick_if.sv ***
/*
 interface carrying timer settings from the top to the prescaler.
 assumes the top drives enable, ps_sel and raw_tick and the prescaler drives tick.
*/
`timescale 1ns/1ps
interface uht_tick_if;
    logic enable;
    logic [1:0] ps_sel;
    logic raw_tick;
    logic tick;
    modport ctl (output enable, output ps_sel, output raw_tick, input tick);
    modport pre (input enable, input ps_sel, input raw_tick, output tick);
endinterface

// *** design/uht_prescaler.sv ***
/*
 input prescaler: divides raw ticks by 1, 8, 64 or 256.
 assumes raw_tick is a one-cycle pulse on clk.
*/
`timescale 1ns/1ps
module uht_prescaler
    import uht_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // settings and tick
    uht_tick_if.pre tif
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic [7:0] tc;

    always_comb
    begin
        unique case (tif.ps_sel)
            UHT_PS_1: tc = UHT_TC_1;
            UHT_PS_8: tc = UHT_TC_8;
            UHT_PS_64: tc = UHT_TC_64;
            UHT_PS_256: tc = UHT_TC_256;
        endcase
        cnt_nxt = cnt_r;
        tif.tick = 1'b0;
        if (!tif.enable)
        begin
            // stopping clears the prescaler so a restart is aligned
            cnt_nxt = UHT_PS_RST;
        end
        else if (tif.raw_tick)
        begin
            if (cnt_r >= tc)
            begin
                cnt_nxt = UHT_PS_RST;
                tif.tick = 1'b1;
            end
            else
            begin
                cnt_nxt = cnt_r + 8'h01;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            cnt_r <= UHT_PS_RST;
        else
            cnt_r <= cnt_nxt;
    end
endmodule

// *** sim/uht_top_properties.sv ***
/*
 port checker for uht_top, bound into every instance.
 assumes writes use byte lanes 0 and 1 together.
*/
`timescale 1ns/1ps
module uht_top_properties
    import uht_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // state, pins, status
    input wire logic device_idle,
    input wire logic pair_32bit_mode,
    input wire logic [15:0] lower_timer_control,
    input wire logic gate_pin,
    input wire logic [15:0] count_out,
    input wire logic counting
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [15:0] ctl_r;
    logic [15:0] ctl_nxt;
    logic [15:0] eff;
    logic wr;
    assign wr = cyc_i && stb_i && we_i && !ack_o;
    // pair mode hands the settings but idle halt to the lower timer
    assign eff = pair_32bit_mode ? lower_timer_control : ctl_r;
    always_comb
    begin
        ctl_nxt = ctl_r;
        if (wr && adr_i == UHT_CTRL_OFS)
            ctl_nxt = dat_i[15:0] & UHT_CTRL_MASK;
    end
    always_ff @(posedge clk)
        ctl_r <= rst ? UHT_CTRL_RST : ctl_nxt;
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    property p_ack;
        s_req |=> ack_o ##1 !ack_o;
    endproperty
    property p_ctl_rd;
        ack_o && !we_i && adr_i == UHT_CTRL_OFS |-> dat_o == {16'h0000, ctl_r};
    endproperty
    property p_stop;
        !eff[15] |-> !counting;
    endproperty
    property p_halt;
        device_idle && ctl_r[13] |-> !counting;
    endproperty
    property p_ext_run;
        eff[15] && eff[1] && !(device_idle && ctl_r[13]) |-> counting;
    endproperty
    property p_gate;
        (!gate_pin)[*4] ##0 (eff[6] && !eff[1]) |-> !counting;
    endproperty
    property p_hold;
        (!counting && !wr)[*2] |=> $stable(count_out);
    endproperty
    property p_inc;
        (counting && !wr && !eff[1] && eff[5:4] == UHT_PS_1)[*2]
            |=> count_out == $past(count_out) + 16'h0001;
    endproperty
    a_ack: assert property (p_ack) else $error("ack timing wrong");
    a_ctl_rd: assert property (p_ctl_rd) else $error("ctrl readback");
    a_stop: assert property (p_stop) else $error("counts unrun");
    a_halt: assert property (p_halt) else $error("runs in idle");
    a_ext_run: assert property (p_ext_run) else $error("ext stalled");
    a_gate: assert property (p_gate) else $error("gate ignored");
    a_hold: assert property (p_hold) else $error("count moved");
    a_inc: assert property (p_inc) else $error("no step");
endmodule
bind uht_top uht_top_properties u_props (.clk(clk), .rst(rst), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .device_idle(device_idle), .gate_pin(gate_pin),
    .pair_32bit_mode(pair_32bit_mode), .counting(counting),
    .lower_timer_control(lower_timer_control), .count_out(count_out));

// *** sim/uht_pin_model.sv ***
/*
 model of the count and gate pins.
 assumes the bench calls its tasks just after a clock edge.
*/
`timescale 1ns/1ps
module uht_pin_model
(
    // clock
    input wire logic clk,
    // pins into the timer
    output logic external_count_pin,
    output logic gate_pin
);
    initial
    begin
        external_count_pin = 1'b0;
        gate_pin = 1'b0;
    end
    // wide phases so the two-stage synchroniser sees each one
    task automatic pulse(input int n);
        repeat (n)
        begin
            repeat (4) @(posedge clk);
            external_count_pin <= 1'b1;
            repeat (4) @(posedge clk);
            external_count_pin <= 1'b0;
        end
    endtask
    task automatic gate(input logic lvl);
        @(posedge clk);
        gate_pin <= lvl;
    endtask
endmodule

// *** sim/tb_top.sv ***
/*
 testbench for uht_top: wishbone tasks, pin model, checks.
 assumes the bound port checker.
*/
`timescale 1ns/1ps
module tb_top;
    import uht_pkg::*;
    logic clk = 1'b0, rst = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic device_idle = 1'b0, pair_32bit_mode = 1'b0, ack_o, counting;
    logic external_count_pin, gate_pin;
    logic [3:0] adr_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic [15:0] lower_timer_control = 16'h0000, count_out, count_np;
    int failures = 0, checked = 0;
    int divs[4] = '{1, 8, 64, 256};
    always #50 clk = ~clk;
    uht_top uut (.clk(clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(4'h3), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .device_idle(device_idle),
        .pair_32bit_mode(pair_32bit_mode),
        .lower_timer_control(lower_timer_control),
        .external_count_pin(external_count_pin), .gate_pin(gate_pin),
        .count_out(count_out), .counting(counting));
    // same bus and pins, but built without the count pin
    uht_top #(.HAS_EXT_PIN(1'b0)) uut_np (.clk(clk), .rst(rst),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(4'h3), .dat_i(dat_i), .dat_o(), .ack_o(),
        .device_idle(device_idle), .pair_32bit_mode(pair_32bit_mode),
        .lower_timer_control(lower_timer_control),
        .external_count_pin(external_count_pin), .gate_pin(gate_pin),
        .count_out(count_np), .counting());
    uht_pin_model pm (.clk(clk), .external_count_pin(external_count_pin),
        .gate_pin(gate_pin));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // one classic cycle, then one idle edge so requests never abut
    task automatic wb(input logic w, input logic [3:0] a,
        input logic [15:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {16'h0000, d};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack_o !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            check(32'h1, 32'h0);
            tally_and_finish();
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [15:0] e);
        wb(1'b0, a, 16'h0000);
        check(rd, {16'h0000, e});
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdc(UHT_CTRL_OFS, UHT_CTRL_RST);
        rdc(UHT_COUNT_OFS, UHT_COUNT_RST);
        wb(1'b1, UHT_CTRL_OFS, 16'hFFFF);
        rdc(UHT_CTRL_OFS, UHT_CTRL_MASK);
        rdc(4'hC, 16'h0000);
        $display("access test done");
        foreach (divs[i])
        begin
            wb(1'b1, UHT_CTRL_OFS, 16'h0000);
            wb(1'b1, UHT_COUNT_OFS, 16'h0000);
            wb(1'b1, UHT_CTRL_OFS, {4'h8, 6'h00, 2'(i), 4'h0});
            repeat (16 * divs[i]) @(posedge clk);
            wb(1'b1, UHT_CTRL_OFS, 16'h0000);
            wb(1'b0, UHT_COUNT_OFS, 16'h0000);
            check({31'h0, rd >= 16 && rd <= 17 + 8 / divs[i]}, 32'h1);
        end
        repeat (20) @(posedge clk);
        rdc(UHT_COUNT_OFS, rd[15:0]);
        $display("prescale test done");
        device_idle <= 1'b1;
        wb(1'b1, UHT_CTRL_OFS, 16'hA000);
        check(counting, 1'b0);
        wb(1'b1, UHT_CTRL_OFS, 16'h8000);
        check(counting, 1'b1);
        device_idle <= 1'b0;
        wb(1'b1, UHT_CTRL_OFS, 16'h8040);
        repeat (5) @(posedge clk);
        check(counting, 1'b0);
        pm.gate(1'b1);
        repeat (5) @(posedge clk);
        check(counting, 1'b1);
        pm.gate(1'b0);
        wb(1'b1, UHT_CTRL_OFS, 16'h8042);
        check(counting, 1'b1);
        wb(1'b1, UHT_COUNT_OFS, 16'h0000);
        pm.pulse(5);
        repeat (8) @(posedge clk);
        rdc(UHT_COUNT_OFS, 16'h0005);
        check({16'h0000, count_np}, 32'h0);
        $display("idle, gate and pin tests done");
        pair_32bit_mode <= 1'b1;
        wb(1'b1, UHT_CTRL_OFS, 16'h8000);
        check(counting, 1'b0);
        lower_timer_control <= 16'h8000;
        @(posedge clk);
        check(counting, 1'b1);
        $display("pair test done");
        tally_and_finish();
    end
endmodule
